// >>> verilog/cts_defines.svh
// constants for the charger timer, control and status registers
`ifndef CTS_DEFINES_SVH
`define CTS_DEFINES_SVH

// ==========================================================
// register offsets
`define CTS_ADDR_TIMER      8'h06
`define CTS_ADDR_FUNC       8'h07
`define CTS_ADDR_STATUS     8'h08

// ==========================================================
// field positions
`define CTS_BIT_CMPL_EN     3
`define CTS_BIT_TMR_EN      2
`define CTS_BIT_JEITA_EN    7
`define CTS_BIT_COOL_SEL    6
`define CTS_BIT_ISO_OFF     4
`define CTS_BIT_REG_EN      3
`define CTS_BIT_EOC_EN      2
`define CTS_BIT_ADAPT_EN    1
`define CTS_BIT_CHG_EN      0
`define CTS_BIT_SUPPLY      7
`define CTS_BIT_ADAPT_ACT   6
`define CTS_BIT_ILIM        5

// ==========================================================
// reset values and writable masks
`define CTS_RST_TIMER       8'h07
`define CTS_RST_FUNC        8'h0c
`define CTS_MASK_TIMER      8'h0f
`define CTS_MASK_FUNC       8'hdf

// ==========================================================
// timing
`define CTS_CLK_NS          4
`define CTS_TICK_NS         1000000
`define CTS_DEGLITCH_MS     32
`define CTS_MIN_MS          60000
`define CTS_TRK_STEP_MIN    15
`define CTS_CHG_STEP_MIN    150
`define CTS_END_MIN         30

`endif

// >>> verilog/cts_pkg.sv
// types shared by the charger timer and status logic
`default_nettype none
package cts_pkg;
  `include "cts_defines.svh"

  // charger sequencing states
  typedef enum logic [2:0] {
    ST_OFF, ST_TRICKLE, ST_FAST_CC, ST_FAST_CV,
    ST_COMPLETE, ST_LDO, ST_TIMEOUT, ST_DETECT
  } cts_state_type;

  // state to reported status code
  function automatic logic [2:0] stateCode(input cts_state_type s);
    unique case (s)
      ST_OFF:      stateCode = 3'h0;
      ST_TRICKLE:  stateCode = 3'h1;
      ST_FAST_CC:  stateCode = 3'h2;
      ST_FAST_CV:  stateCode = 3'h3;
      ST_COMPLETE: stateCode = 3'h4;
      ST_LDO:      stateCode = 3'h5;
      ST_TIMEOUT:  stateCode = 3'h6;
      ST_DETECT:   stateCode = 3'h7;
    endcase
  endfunction : stateCode
endpackage : cts_pkg
`default_nettype wire

// >>> verilog/cts_phase_timer.sv
// tick counter with a programmable limit and expiry flag
`default_nettype none
module cts_phase_timer #(
  parameter int W = 26
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         tick,
  input  wire logic         run,
  input  wire logic         clear,
  input  wire logic [W-1:0] limit,
  output logic              expired
);
  import cts_pkg::*;

  logic [W-1:0] count_q;

  // ==========================================================
  // counting; holds at the limit so it never wraps
  assign expired = (count_q >= limit);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || clear)
      count_q <= '0;
    else if (run && tick && !expired)
      count_q <= count_q + W'(1);
  end
endmodule : cts_phase_timer
`default_nettype wire

// >>> verilog/cts_deglitch.sv
// level qualifier: output rises after the input holds for N ticks
`default_nettype none
`include "cts_defines.svh"
module cts_deglitch #(
  parameter int N = `CTS_DEGLITCH_MS
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic tick,
  input  wire logic level,
  output logic      qualified
);
  import cts_pkg::*;

  logic [7:0] count_q;

  // ==========================================================
  // any drop of the level restarts the filter
  assign qualified = (count_q == 8'(N));

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !level)
      count_q <= 8'h00;
    else if (tick && !qualified)
      count_q <= count_q + 8'h01;
  end
endmodule : cts_deglitch
`default_nettype wire

// >>> verilog/cts_timer_control_status.sv
// charger timer, function control and status registers with sequencing
`default_nettype none
`include "cts_defines.svh"
module cts_timer_control_status #(
  parameter int   TICK_CYCLES = `CTS_TICK_NS / `CTS_CLK_NS,
  parameter int   MIN_TICKS   = `CTS_MIN_MS,
  parameter int   END_MIN     = `CTS_END_MIN,
  parameter logic CHG_EN_INIT = 1'b1
) (
  input  wire logic           ref_clk,
  input  wire logic           rst_n,
  // register port from the serial interface engine
  input  wire logic [7:0]     regAddr,
  input  wire logic [7:0]     regWrData,
  input  wire logic           regWrEn,
  input  wire logic           regRdEn,
  output logic [7:0]          regRdData,
  // analog comparator levels, asynchronous
  input  wire logic           supplyValidPin,
  input  wire logic           batteryPresentPin,
  input  wire logic           aboveDeadPin,
  input  wire logic           cvReachedPin,
  input  wire logic           eocCurrentPin,
  input  wire logic           coolZonePin,
  input  wire logic           adaptiveActivePin,
  input  wire logic           inputLimitedPin,
  // controls to the analog charger
  output logic                chargeRegulatorOn,
  output logic                chargeOn,
  output logic                batteryIsolationSwitchOff,
  output logic                systemRailShutdown,
  output logic                temperatureZoneActive,
  output logic                coolCurrentHalf,
  output logic                coolCurrentTenth,
  output logic                adaptiveLimitOn,
  output cts_pkg::cts_state_type chargerState,
  output logic [2:0]          chargerStateCode
);
  import cts_pkg::*;

  localparam int TW = 26;

  // ==========================================================
  // helpers
  function automatic logic [TW-1:0] limitTicks(input logic [1:0] code,
                                               input int stepMin);
    limitTicks = TW'((int'(code) + 1) * stepMin * MIN_TICKS);
  endfunction : limitTicks

  // ==========================================================
  // declarations
  logic [7:0]    timerReg_q;
  logic [7:0]    funcReg_q;
  logic [7:0]    syncA_q;
  logic [7:0]    syncB_q;
  logic [17:0]   tickCnt_q;
  logic          tick;
  cts_state_type state_q;
  cts_state_type state_d;
  logic [2:0]    code_q;
  logic          chargeOn_q;
  logic          regOn_q;
  logic          isoOff_q;
  logic          railOff_q;
  logic          zoneAct_q;
  logic          coolHalf_q;
  logic          coolTenth_q;
  logic          adaptOn_q;
  logic [7:0]    rdData_q;

  // ==========================================================
  // register fields
  wire completionTimerEnable  = timerReg_q[`CTS_BIT_CMPL_EN];
  wire phaseTimersEnable      = timerReg_q[`CTS_BIT_TMR_EN];
  wire [1:0] phaseTimerLength = timerReg_q[1:0];
  wire temperatureZoneEnable  = funcReg_q[`CTS_BIT_JEITA_EN];
  wire coolZoneCurrentSelect  = funcReg_q[`CTS_BIT_COOL_SEL];
  wire isolationSwitchForceOff = funcReg_q[`CTS_BIT_ISO_OFF];
  wire chargeRegulatorEnable  = funcReg_q[`CTS_BIT_REG_EN];
  wire endOfChargeEnable      = funcReg_q[`CTS_BIT_EOC_EN];
  wire adaptiveLimitEnable    = funcReg_q[`CTS_BIT_ADAPT_EN];
  wire chargingEnable         = funcReg_q[`CTS_BIT_CHG_EN];

  // synchronised comparator levels
  wire supplyValid    = syncB_q[0];
  wire batteryPresent = syncB_q[1];
  wire aboveDead      = syncB_q[2];
  wire cvReached      = syncB_q[3];
  wire eocCurrent     = syncB_q[4];
  wire coolZone       = syncB_q[5];
  wire adaptiveActive = syncB_q[6];
  wire inputLimited   = syncB_q[7];

  // ==========================================================
  // register port decode
  wire wrTimer = regWrEn && (regAddr == `CTS_ADDR_TIMER);
  wire wrFunc  = regWrEn && (regAddr == `CTS_ADDR_FUNC);
  wire [7:0] statusWord = {supplyValid, adaptiveActive, inputLimited,
                           2'b00, stateCode(state_q)};
  wire [7:0] rdMux = (regAddr == `CTS_ADDR_TIMER)  ? timerReg_q :
                     (regAddr == `CTS_ADDR_FUNC)   ? funcReg_q  :
                     (regAddr == `CTS_ADDR_STATUS) ? statusWord :
                     8'h00;

  // writable registers; reserved bits masked off on write
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      timerReg_q <= `CTS_RST_TIMER;
      funcReg_q  <= `CTS_RST_FUNC | {7'h00, CHG_EN_INIT};
    end
    else
    begin
      if (wrTimer)
        timerReg_q <= regWrData & `CTS_MASK_TIMER;
      if (wrFunc)
        funcReg_q <= regWrData & `CTS_MASK_FUNC;
    end
  end

  // read data captured on the read strobe, held until the next read
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      rdData_q <= 8'h00;
    else if (regRdEn)
      rdData_q <= rdMux;
  end
  assign regRdData = rdData_q;

  // ==========================================================
  // two-flop synchronisers; first stage read only by the second
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      syncA_q <= 8'h00;
      syncB_q <= 8'h00;
    end
    else
    begin
      syncA_q <= {inputLimitedPin, adaptiveActivePin, coolZonePin,
                  eocCurrentPin, cvReachedPin, aboveDeadPin,
                  batteryPresentPin, supplyValidPin};
      syncB_q <= syncA_q;
    end
  end

  // ==========================================================
  // millisecond tick for every timer
  assign tick = (tickCnt_q == 18'(TICK_CYCLES - 1));

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || tick)
      tickCnt_q <= 18'h00000;
    else
      tickCnt_q <= tickCnt_q + 18'h00001;
  end

  // ==========================================================
  // timers
  logic trkExpired;
  logic fastExpired;
  logic endExpired;
  logic eocQualified;
  wire [TW-1:0] trkLimit  = limitTicks(phaseTimerLength,
                                       `CTS_TRK_STEP_MIN);
  wire [TW-1:0] fastLimit = limitTicks(phaseTimerLength,
                                       `CTS_CHG_STEP_MIN);
  wire inTrickle = (state_q == ST_TRICKLE);
  wire inFast    = (state_q == ST_FAST_CC) || (state_q == ST_FAST_CV);
  wire trkRun    = phaseTimersEnable && inTrickle;
  wire fastRun   = phaseTimersEnable && inFast;
  // completion timer only counts once the end condition is qualified
  wire endRun    = completionTimerEnable && eocQualified &&
                   (state_q == ST_FAST_CV);

  cts_phase_timer #(.W(TW)) trkTimer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tick    (tick),
    .run     (trkRun),
    .clear   (!inTrickle),
    .limit   (trkLimit),
    .expired (trkExpired)
  );

  cts_phase_timer #(.W(TW)) fastTimer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tick    (tick),
    .run     (fastRun),
    .clear   (!inFast),
    .limit   (fastLimit),
    .expired (fastExpired)
  );

  cts_phase_timer #(.W(TW)) endTimer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tick    (tick),
    .run     (endRun),
    .clear   (!endRun),
    .limit   (TW'(END_MIN * MIN_TICKS)),
    .expired (endExpired)
  );

  // the deglitch filter stays in the path even with the timer off
  cts_deglitch #(.N(`CTS_DEGLITCH_MS)) eocFilter (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .tick      (tick),
    .level     (eocCurrent && (state_q == ST_FAST_CV)),
    .qualified (eocQualified)
  );

  // ==========================================================
  // sequencing
  wire chargeAllowed = supplyValid && chargingEnable &&
                       chargeRegulatorEnable;
  wire trkTimeout  = phaseTimersEnable && trkExpired;
  wire fastTimeout = phaseTimersEnable && fastExpired;
  wire endReached  = endOfChargeEnable && eocQualified &&
                     (!completionTimerEnable || endExpired);

  always_comb
  begin
    state_d = state_q;
    if (!chargeAllowed)
      // regulator alone keeps the system supplied from the input
      state_d = (supplyValid && chargeRegulatorEnable) ? ST_LDO
                                                       : ST_OFF;
    else
      unique case (state_q)
        ST_OFF, ST_LDO: state_d = ST_DETECT;
        ST_DETECT:
          if (batteryPresent)
            state_d = aboveDead ? ST_FAST_CC : ST_TRICKLE;
        ST_TRICKLE:
          if (trkTimeout)
            state_d = ST_TIMEOUT;
          else if (aboveDead)
            state_d = ST_FAST_CC;
        ST_FAST_CC:
          if (fastTimeout)
            state_d = ST_TIMEOUT;
          else if (cvReached)
            state_d = ST_FAST_CV;
        // completion wins over a timeout in the same cycle
        ST_FAST_CV:
          if (endReached)
            state_d = ST_COMPLETE;
          else if (fastTimeout)
            state_d = ST_TIMEOUT;
        ST_COMPLETE, ST_TIMEOUT: state_d = state_q;
      endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_q <= ST_OFF;
      code_q  <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      code_q  <= stateCode(state_d);
    end
  end

  // ==========================================================
  // analog controls, registered
  wire charging_d = (state_d == ST_TRICKLE) || (state_d == ST_FAST_CC) ||
                    (state_d == ST_FAST_CV);
  wire zoneCool   = temperatureZoneEnable && coolZone;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      chargeOn_q  <= 1'b0;
      regOn_q     <= 1'b0;
      isoOff_q    <= 1'b0;
      railOff_q   <= 1'b0;
      zoneAct_q   <= 1'b0;
      coolHalf_q  <= 1'b0;
      coolTenth_q <= 1'b0;
      adaptOn_q   <= 1'b0;
    end
    else
    begin
      chargeOn_q  <= charging_d;
      regOn_q     <= chargeRegulatorEnable;
      isoOff_q    <= isolationSwitchForceOff;
      railOff_q   <= isolationSwitchForceOff && batteryPresent;
      zoneAct_q   <= temperatureZoneEnable;
      coolHalf_q  <= zoneCool && !coolZoneCurrentSelect;
      coolTenth_q <= zoneCool && coolZoneCurrentSelect;
      adaptOn_q   <= adaptiveLimitEnable && charging_d;
    end
  end

  assign chargeOn                  = chargeOn_q;
  assign chargeRegulatorOn         = regOn_q;
  assign batteryIsolationSwitchOff = isoOff_q;
  assign systemRailShutdown        = railOff_q;
  assign temperatureZoneActive     = zoneAct_q;
  assign coolCurrentHalf           = coolHalf_q;
  assign coolCurrentTenth          = coolTenth_q;
  assign adaptiveLimitOn           = adaptOn_q;
  assign chargerState              = state_q;
  assign chargerStateCode          = code_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence sStatusRead;
    regRdEn && (regAddr == `CTS_ADDR_STATUS);
  endsequence

  sequence sEocDirect;
    (state_q == ST_FAST_CV) && chargeAllowed && eocQualified &&
    endOfChargeEnable && !completionTimerEnable;
  endsequence

  a_eoc_no_timer: assert property (
    sEocDirect |=> (state_q == ST_COMPLETE) ##0 (code_q == 3'h4))
    else $error("qualified end of charge did not complete");
  a_timers_gated: assert property (
    (!phaseTimersEnable && state_q != ST_TIMEOUT)
      |=> state_q != ST_TIMEOUT)
    else $error("timeout with phase timers disabled");
  a_period_ratio: assert property (
    fastLimit == TW'(trkLimit * 10))
    else $error("fast limit is not ten times trickle limit");
  a_timeout_code: assert property (
    (chargeAllowed && inTrickle && trkTimeout) |=> code_q == 3'h6)
    else $error("trickle timeout not reported");
  a_zone_off: assert property (
    !temperatureZoneEnable |=> !coolCurrentHalf && !coolCurrentTenth)
    else $error("cool reduction with zones disabled");
  a_cool_select: assert property (
    (temperatureZoneEnable && coolZone)
      |=> (coolCurrentTenth == $past(coolZoneCurrentSelect)) &&
          (coolCurrentHalf != coolCurrentTenth))
    else $error("cool current select wrong");
  a_iso_rail: assert property (
    (isolationSwitchForceOff && !batteryPresent)
      |=> batteryIsolationSwitchOff && !systemRailShutdown)
    else $error("isolation force-off wrong");
  a_regulator_off: assert property (
    !chargeRegulatorEnable |=> !chargeRegulatorOn && !chargeOn)
    else $error("regulator active while disabled");
  a_eoc_gated: assert property (
    (!endOfChargeEnable && state_q != ST_COMPLETE)
      |=> state_q != ST_COMPLETE)
    else $error("end of charge while disabled");
  a_adaptive_gate: assert property (
    adaptiveLimitOn |-> $past(adaptiveLimitEnable) && chargeOn)
    else $error("adaptive limit without enable or charge");
  a_charge_gate: assert property (
    !chargingEnable |=> !chargeOn ##1 !chargeOn || chargingEnable)
    else $error("charging while charge enable low");
  a_status_bits: assert property (
    sStatusRead |=> regRdData[7:5] ==
      $past({supplyValid, adaptiveActive, inputLimited}))
    else $error("status flags misreported");
  a_state_code: assert property (
    (state_q == ST_LDO) |-> code_q == 3'h5)
    else $error("regulator mode code wrong");
  a_reserved_zero: assert property (
    (regRdEn && regAddr == `CTS_ADDR_TIMER) |=> regRdData[7:4] == 4'h0)
    else $error("reserved timer bits not zero");
endmodule : cts_timer_control_status
`default_nettype wire

// >>> test/cts_front_model.sv
// analog charger front end model driving the comparator levels
`default_nettype none
module cts_front_model (
  input  wire logic [7:0] levelCmd,
  output logic            supplyValidPin,
  output logic            batteryPresentPin,
  output logic            aboveDeadPin,
  output logic            cvReachedPin,
  output logic            eocCurrentPin,
  output logic            coolZonePin,
  output logic            adaptiveActivePin,
  output logic            inputLimitedPin
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // comparators
  // battery levels only exist with a cell fitted, input flags need supply
  assign supplyValidPin    = levelCmd[7];
  assign batteryPresentPin = levelCmd[6];
  assign aboveDeadPin      = levelCmd[6] & levelCmd[5];
  assign cvReachedPin      = levelCmd[6] & levelCmd[4];
  assign eocCurrentPin     = levelCmd[6] & levelCmd[3];
  assign coolZonePin       = levelCmd[6] & levelCmd[2];
  assign adaptiveActivePin = levelCmd[7] & levelCmd[1];
  assign inputLimitedPin   = levelCmd[7] & levelCmd[0];
endmodule : cts_front_model
`default_nettype wire

// >>> test/test_cts_timer_control_status.sv
// self-checking bench for the charger timer, control and status block
`default_nettype none
`include "cts_defines.svh"
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin \
  miscompares++; $display("unexpected at %0t: got %h expected %h", \
  $time, g, e); end end
module test_cts_timer_control_status;
  timeunit 1ns;
  timeprecision 1ns;
  import cts_pkg::*;

  // ==========================================================
  // stimulus and observed signals
  logic       ref_clk   = 1'b0;
  logic       rst_n     = 1'b0;
  logic [7:0] regAddr   = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic       regWrEn   = 1'b0;
  logic       regRdEn   = 1'b0;
  logic [7:0] levelCmd  = 8'h00;
  logic [7:0] regRdData, rd;
  logic       supplyValidPin, batteryPresentPin, aboveDeadPin;
  logic       cvReachedPin, eocCurrentPin, coolZonePin;
  logic       adaptiveActivePin, inputLimitedPin;
  logic       chargeRegulatorOn, chargeOn, batteryIsolationSwitchOff;
  logic       systemRailShutdown, temperatureZoneActive;
  logic       coolCurrentHalf, coolCurrentTenth, adaptiveLimitOn;
  logic [2:0] chargerStateCode;
  cts_state_type chargerState;
  int         miscompares = 0;
  int         checkCount  = 0;

  // ==========================================================
  // clock and instances
  always #2 ref_clk = ~ref_clk;

  // shortened ticks keep the trickle timer within 480 cycles and the fast timer within 4800
  cts_timer_control_status #(
    .TICK_CYCLES(4), .MIN_TICKS(2), .END_MIN(20), .CHG_EN_INIT(1'b1)
  ) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .supplyValidPin(supplyValidPin),
    .batteryPresentPin(batteryPresentPin), .aboveDeadPin(aboveDeadPin),
    .cvReachedPin(cvReachedPin), .eocCurrentPin(eocCurrentPin),
    .coolZonePin(coolZonePin), .adaptiveActivePin(adaptiveActivePin),
    .inputLimitedPin(inputLimitedPin),
    .chargeRegulatorOn(chargeRegulatorOn), .chargeOn(chargeOn),
    .batteryIsolationSwitchOff(batteryIsolationSwitchOff),
    .systemRailShutdown(systemRailShutdown),
    .temperatureZoneActive(temperatureZoneActive),
    .coolCurrentHalf(coolCurrentHalf), .coolCurrentTenth(coolCurrentTenth),
    .adaptiveLimitOn(adaptiveLimitOn), .chargerState(chargerState),
    .chargerStateCode(chargerStateCode)
  );

  cts_front_model front_u (
    .levelCmd(levelCmd), .supplyValidPin(supplyValidPin),
    .batteryPresentPin(batteryPresentPin), .aboveDeadPin(aboveDeadPin),
    .cvReachedPin(cvReachedPin), .eocCurrentPin(eocCurrentPin),
    .coolZonePin(coolZonePin), .adaptiveActivePin(adaptiveActivePin),
    .inputLimitedPin(inputLimitedPin)
  );

  // ==========================================================
  // register port tasks
  task automatic finalReport;
    if (miscompares == 0 && checkCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finalReport

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
  endtask : wr

  // data is registered, so it is taken one edge after the strobe
  task automatic rdx(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask : rdx

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rdx(a, rd);
    `CHK(rd, e)
  endtask : rchk

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle

  task automatic lv(input logic [7:0] v);
    @(posedge ref_clk);
    levelCmd <= v;
  endtask : lv

  // polls the state code; a bound that runs out ends the run
  task automatic waitCode(input logic [2:0] c, input int n);
    int i;
    for (i = 0; i < n; i++)
    begin
      rdx(`CTS_ADDR_STATUS, rd);
      if (rd[2:0] === c)
        break;
    end
    if (i == n)
    begin
      miscompares++;
      finalReport();
    end
    else
      `CHK(rd[2:0], c)
  endtask : waitCode

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rchk(8'h06, 8'h07);
    rchk(8'h07, 8'h0d);
    rchk(8'h08, 8'h00);
    rchk(8'h09, 8'h00);
    wr(8'h06, 8'hf0);
    rchk(8'h06, 8'h00);
    wr(8'h07, 8'hff);
    rchk(8'h07, 8'hdf);
    idle(2);
    `CHK(temperatureZoneActive, 1'b1)
    `CHK(batteryIsolationSwitchOff, 1'b1)
    `CHK(systemRailShutdown, 1'b0)
    `CHK(adaptiveLimitOn, 1'b0)
    lv(8'hc0);
    // each period code: still trickle just short of the limit
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h06, 8'h04 | 8'(k));
      wr(8'h07, 8'h0c);
      waitCode(3'h5, 20);
      wr(8'h07, 8'h0d);
      waitCode(3'h1, 20);
      idle((k + 1) * 120 - 30);
      rchk(8'h08, 8'h81);
      waitCode(3'h6, 40);
      `CHK(chargeOn, 1'b0)
    end
    wr(8'h06, 8'h00);
    wr(8'h07, 8'h0c);
    wr(8'h07, 8'h0d);
    waitCode(3'h1, 20);
    idle(300);
    rchk(8'h08, 8'h81);
    lv(8'he0);
    waitCode(3'h2, 20);
    `CHK(chargeOn, 1'b1)
    wr(8'h07, 8'h0f);
    idle(2);
    `CHK(adaptiveLimitOn, 1'b1)
    lv(8'he3);
    idle(4);
    rchk(8'h08, 8'he2);
    `CHK(chargerStateCode, 3'h2)
    `CHK(chargerState, ST_FAST_CC)
    lv(8'he4);
    wr(8'h07, 8'h0d);
    idle(4);
    `CHK(coolCurrentHalf, 1'b0)
    wr(8'h07, 8'h8d);
    idle(2);
    `CHK(coolCurrentHalf, 1'b1)
    wr(8'h07, 8'hcd);
    idle(2);
    `CHK({coolCurrentHalf, coolCurrentTenth}, 2'b01)
    wr(8'h07, 8'h1d);
    idle(2);
    `CHK(systemRailShutdown, 1'b1)
    wr(8'h07, 8'h05);
    idle(2);
    `CHK(chargeRegulatorOn, 1'b0)
    waitCode(3'h0, 10);
    wr(8'h07, 8'h0d);
    lv(8'hf0);
    waitCode(3'h3, 20);
    // the taper level must hold for the deglitch before completing
    lv(8'hf8);
    idle(100);
    rchk(8'h08, 8'h83);
    waitCode(3'h4, 40);
    wr(8'h07, 8'h0c);
    wr(8'h07, 8'h09);
    waitCode(3'h3, 20);
    idle(200);
    rchk(8'h08, 8'h83);
    wr(8'h07, 8'h0d);
    waitCode(3'h4, 10);
    // completion timer on: a qualified end also waits out its length
    wr(8'h06, 8'h08);
    wr(8'h07, 8'h0c);
    wr(8'h07, 8'h0d);
    waitCode(3'h3, 20);
    idle(200);
    rchk(8'h08, 8'h83);
    waitCode(3'h4, 60);
    finalReport();
  end
endmodule : test_cts_timer_control_status
`default_nettype wire
